// >>> intc_status_pkg.sv
/*
 interrupt status and pending view: register map, field positions,
 reset values and widths shared by the design.
 assumes a 32-bit apb slave with 9-bit byte address.
*/
package intc_status_pkg;
  // page 0 global, pages 1..4 one per core
  localparam int ADDR_W = 9;
  localparam int PAGE_LSB = 6;
  localparam logic [2:0] PAGE_GLOBAL = 3'h0;
  localparam logic [2:0] PAGE_CORE0 = 3'h1;
  // global page offsets
  localparam logic [5:0] OFS_RAW_LOW = 6'h00;
  localparam logic [5:0] OFS_RAW_MID = 6'h04;
  localparam logic [5:0] OFS_RAW_HIGH = 6'h08;
  localparam logic [5:0] OFS_CFG = 6'h0C;
  localparam logic [5:0] OFS_SW_SET = 6'h10;
  localparam logic [5:0] OFS_SW_CLR = 6'h14;
  // per-core page offsets
  localparam logic [5:0] OFS_PEND_LOW = 6'h00;
  localparam logic [5:0] OFS_PEND_MID = 6'h04;
  localparam logic [5:0] OFS_PEND_HIGH = 6'h08;
  localparam logic [5:0] OFS_SET_EN0 = 6'h10;
  localparam logic [5:0] OFS_SET_EN1 = 6'h14;
  localparam logic [5:0] OFS_SET_EN2 = 6'h18;
  localparam logic [5:0] OFS_CLR_EN0 = 6'h20;
  localparam logic [5:0] OFS_CLR_EN1 = 6'h24;
  localparam logic [5:0] OFS_CLR_EN2 = 6'h28;
  // top word field positions
  localparam int BIT_HOST = 31;
  localparam int BIT_SUM_MID = 25;
  localparam int BIT_SUM_LOW = 24;
  localparam int SW_LSB = 8;
  localparam int SW_W = 8;
  localparam int BIT_AXI = 7;
  localparam int BIT_ADDR = 6;
  localparam int BIT_HALT1 = 5;
  localparam int BIT_HALT0 = 4;
  localparam int BIT_BELL1 = 3;
  localparam int BIT_BELL0 = 2;
  localparam int BIT_MBOX = 1;
  localparam int BIT_TIMER = 0;
  localparam int CFG_PAIR_HALT = 10;
  // implemented source bits of the top word
  localparam logic [31:0] HIGH_SRC_MASK = 32'h8000FFFF;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  localparam logic [SW_W-1:0] SW_RESET = 8'h00;
endpackage

// >>> interrupt_status_pending_view.sv
/*
 interrupt status and pending view with apb register access,
 per-core enables, software triggers and local sticky sources.
 assumes all source inputs are logic on clk_sys (no synchroniser)
 and a well-behaved apb master.
 fast_irq is combinational: a core that needs a clean edge registers it.
 an unmapped access answers with pslverr and reads as zero.
*/
// Our own choices: the APB interface to the registers and the placing of the registers.
module interrupt_status_pending_view #(
  parameter int NUM_CORES = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [intc_status_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt sources
  input wire logic [31:0] source_bits_low,
  input wire logic [31:0] source_bits_mid,
  input wire logic host_irq,
  input wire logic axi_error,
  input wire logic burst_valid,
  input wire logic [7:0] burst_len,
  input wire logic burst_to_vp_space,
  input wire logic first_core_halt,
  input wire logic second_core_halt,
  input wire logic [1:0] doorbell_set,
  input wire logic [1:0] doorbell_read,
  input wire logic mailbox_zero_flag,
  input wire logic timer_event,
  input wire logic timer_ctrl_write,
  input wire logic cluster_reset,
  output logic [NUM_CORES-1:0] fast_irq
);

  // whole state of the block
  typedef struct packed {
    logic [intc_status_pkg::SW_W-1:0] sw; // software triggers
    logic axi_err; // sticky bus error
    logic addr_err; // sticky burst range error
    logic [1:0] bell; // doorbell flags
    logic timer; // timer flag
    logic pair_halt; // config bit 10
    logic [NUM_CORES-1:0][2:0][31:0] en; // per-core enables
    logic [31:0] rdata; // read data latched at setup
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic [31:0] raw_high; // top raw word
  logic [NUM_CORES-1:0][2:0][31:0] pend; // per-core pending words
  logic setup_rd; // read setup phase
  logic acc_wr; // write access phase
  logic [2:0] page; // address page
  logic [5:0] ofs; // offset inside page
  logic hit; // address is mapped

  // mask of enable bits that exist in word w
  function automatic logic [31:0] src_mask(input int w);
    src_mask = (w == 2) ? intc_status_pkg::HIGH_SRC_MASK : ~intc_status_pkg::ZERO_WORD;
  endfunction

  // is this offset a mapped register of the page
  function automatic logic mapped(input logic [2:0] pg, input logic [5:0] o);
    logic core_pg;
    core_pg = (pg >= intc_status_pkg::PAGE_CORE0) &&
              (pg < intc_status_pkg::PAGE_CORE0 + 3'(NUM_CORES));
    if (pg == intc_status_pkg::PAGE_GLOBAL) begin
      mapped = (o <= intc_status_pkg::OFS_SW_CLR) && (o[1:0] == 2'b00);
    end else if (core_pg) begin
      mapped = (o[1:0] == 2'b00) && (o[3:2] != 2'b11) &&
               (o <= intc_status_pkg::OFS_CLR_EN2) && (o[5:4] != 2'b00 ||
               o <= intc_status_pkg::OFS_PEND_HIGH);
    end else begin
      mapped = 1'b0;
    end
  endfunction

  assign page = paddr[intc_status_pkg::ADDR_W-1:intc_status_pkg::PAGE_LSB];
  assign ofs = paddr[intc_status_pkg::PAGE_LSB-1:0];
  assign hit = mapped(page, ofs);
  assign setup_rd = psel && !penable && !pwrite;
  assign acc_wr = psel && penable && pwrite;

  // top raw word, reserved bits held at zero
  always_comb begin
    raw_high = intc_status_pkg::ZERO_WORD;
    raw_high[intc_status_pkg::BIT_HOST] = host_irq;
    raw_high[intc_status_pkg::SW_LSB +: intc_status_pkg::SW_W] = s_reg.sw;
    raw_high[intc_status_pkg::BIT_AXI] = s_reg.axi_err;
    raw_high[intc_status_pkg::BIT_ADDR] = s_reg.addr_err;
    raw_high[intc_status_pkg::BIT_HALT1] = second_core_halt;
    // halt bit 4 also shows the second core when paired
    raw_high[intc_status_pkg::BIT_HALT0] = first_core_halt ||
      (s_reg.pair_halt && second_core_halt);
    raw_high[intc_status_pkg::BIT_BELL1] = s_reg.bell[1];
    raw_high[intc_status_pkg::BIT_BELL0] = s_reg.bell[0];
    // mailbox level passes straight through
    raw_high[intc_status_pkg::BIT_MBOX] = mailbox_zero_flag;
    raw_high[intc_status_pkg::BIT_TIMER] = s_reg.timer;
  end

  // pending words, one copy per core
  for (genvar c = 0; c < NUM_CORES; c++) begin : g_core
    always_comb begin
      pend[c][0] = source_bits_low & s_reg.en[c][0];
      pend[c][1] = source_bits_mid & s_reg.en[c][1];
      pend[c][2] = raw_high & s_reg.en[c][2];
      // summaries overwrite bits 25 and 24, which no source drives
      pend[c][2][intc_status_pkg::BIT_SUM_MID] = |pend[c][1];
      pend[c][2][intc_status_pkg::BIT_SUM_LOW] = |pend[c][0];
    end
    // summaries are already covered by the lower words
    assign fast_irq[c] = |pend[c][0] || |pend[c][1] ||
      |(pend[c][2] & intc_status_pkg::HIGH_SRC_MASK);
  end

  // next state: sources, register writes, read capture
  always_comb begin
    logic [31:0] rd;
    logic [2:0] ci;
    int w;
    rd = intc_status_pkg::ZERO_WORD;
    ci = page - intc_status_pkg::PAGE_CORE0;
    w = 0;
    s_next = s_reg;
    // clears first so that a same-cycle set wins
    if (cluster_reset) begin
      s_next.axi_err = 1'b0;
      s_next.addr_err = 1'b0;
    end
    // a doorbell read drops its flag
    s_next.bell = s_reg.bell & ~doorbell_read;
    // a timer control write drops the timer flag
    if (timer_ctrl_write) begin
      s_next.timer = 1'b0;
    end
    // sets below override the clears above
    if (axi_error) begin
      s_next.axi_err = 1'b1;
    end
    if (burst_valid && burst_to_vp_space && (burst_len != 8'h00)) begin
      s_next.addr_err = 1'b1;
    end
    s_next.bell = s_next.bell | doorbell_set;
    if (timer_event) begin
      s_next.timer = 1'b1;
    end
    // writes take effect in the access phase only
    if (acc_wr && hit) begin
      if (page == intc_status_pkg::PAGE_GLOBAL) begin
        unique case (ofs)
          intc_status_pkg::OFS_CFG: begin
            s_next.pair_halt = pwdata[intc_status_pkg::CFG_PAIR_HALT];
          end
          intc_status_pkg::OFS_SW_SET: begin
            s_next.sw = s_reg.sw | pwdata[intc_status_pkg::SW_W-1:0];
          end
          intc_status_pkg::OFS_SW_CLR: begin
            s_next.sw = s_reg.sw & ~pwdata[intc_status_pkg::SW_W-1:0];
          end
          // raw words are read-only
          default: begin
            s_next.sw = s_reg.sw;
          end
        endcase
      end else begin
        // core page: word index from offset bits 3:2
        w = int'(ofs[3:2]);
        // enable set: bits that do not exist stay zero
        if (ofs[5:4] == 2'b01 && w < 3) begin
          s_next.en[ci][w] = s_reg.en[ci][w] | (pwdata & src_mask(w));
        // enable clear: a one disables that source
        end else if (ofs[5:4] == 2'b10 && w < 3) begin
          s_next.en[ci][w] = s_reg.en[ci][w] & ~pwdata;
        end
      end
    end
    // read data is built in setup so it comes from a flop
    if (setup_rd) begin
      if (!hit) begin
        // unmapped read gives zero, pslverr follows in access
        rd = intc_status_pkg::ZERO_WORD;
      end else if (page == intc_status_pkg::PAGE_GLOBAL) begin
        unique case (ofs)
          intc_status_pkg::OFS_RAW_LOW: begin
            rd = source_bits_low;
          end
          intc_status_pkg::OFS_RAW_MID: begin
            rd = source_bits_mid;
          end
          intc_status_pkg::OFS_RAW_HIGH: begin
            rd = raw_high;
          end
          intc_status_pkg::OFS_CFG: begin
            rd[intc_status_pkg::CFG_PAIR_HALT] = s_reg.pair_halt;
          end
          default: begin
            rd[intc_status_pkg::SW_W-1:0] = s_reg.sw;
          end
        endcase
      end else begin
        // core page: pending words, or enable readback
        w = int'(ofs[3:2]);
        if (ofs[5:4] == 2'b00) begin
          rd = pend[ci][w];
        end else begin
          rd = s_reg.en[ci][w];
        end
      end
      s_next.rdata = rd;
    end
  end

  // single state register
  // limitation: reset drops all enables, software must enable again
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // zero-wait slave: answer in the access phase
  // trade-off: read data costs a flop stage but needs no wait state
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = s_reg.rdata;

  // assertions sample on the system clock and sleep in reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // sticky error sources
  chk_axi_hold: assert property (s_reg.axi_err && !cluster_reset |=> s_reg.axi_err)
    else $error("bus error flag dropped without cluster reset");
  chk_axi_set: assert property (axi_error |=> s_reg.axi_err)
    else $error("bus error not captured");
  chk_addr_set: assert property (burst_valid && burst_to_vp_space && burst_len != 8'h00
    |=> raw_high[intc_status_pkg::BIT_ADDR])
    else $error("burst range error not captured");
  // clearable local sources
  chk_bell_set: assert property (doorbell_set[1]
    |=> raw_high[intc_status_pkg::BIT_BELL1])
    else $error("doorbell flag not captured");
  chk_bell_clear: assert property (doorbell_read[0] && !doorbell_set[0]
    |=> !raw_high[intc_status_pkg::BIT_BELL0])
    else $error("doorbell flag survived its read");
  chk_timer_clear: assert property (timer_ctrl_write && !timer_event
    |=> !raw_high[intc_status_pkg::BIT_TIMER])
    else $error("timer flag survived control write");
  // software bits and paired halt
  chk_sw_keep: assert property (!(acc_wr && page == intc_status_pkg::PAGE_GLOBAL &&
    ofs == intc_status_pkg::OFS_SW_CLR) |=> (s_reg.sw & $past(s_reg.sw)) == $past(s_reg.sw))
    else $error("software trigger lost without clear write");
  chk_halt_pair: assert property (raw_high[intc_status_pkg::BIT_HALT0] ==
    (first_core_halt || (s_reg.pair_halt && second_core_halt)))
    else $error("paired halt bit wrong");
  // read path
  chk_raw_read: assert property (setup_rd && page == intc_status_pkg::PAGE_GLOBAL &&
    ofs == intc_status_pkg::OFS_RAW_LOW ##1 psel && penable |-> prdata == $past(source_bits_low))
    else $error("raw low read mismatch");
  chk_unmapped_read: assert property (setup_rd && !hit
    |=> prdata == intc_status_pkg::ZERO_WORD)
    else $error("unmapped read returned data");
  // fast lines and summaries
  chk_fast_line: assert property (fast_irq[0] == (|(source_bits_low & s_reg.en[0][0]) ||
    |(source_bits_mid & s_reg.en[0][1]) || |(raw_high & s_reg.en[0][2])))
    else $error("fast line disagrees with enabled sources");
  chk_sum_low: assert property (pend[0][2][intc_status_pkg::BIT_SUM_LOW] ==
    |(source_bits_low & s_reg.en[0][0]))
    else $error("low summary bit wrong");
  chk_sum_mid: assert property (pend[0][2][intc_status_pkg::BIT_SUM_MID] ==
    |(source_bits_mid & s_reg.en[0][1]))
    else $error("middle summary bit wrong");
  chk_core_isolate: assert property (s_reg.en[1] == '0 |-> !fast_irq[1])
    else $error("core without enables raised its fast line");

endmodule // interrupt_status_pending_view

// >>> fast_irq_monitor.sv
/*
 stand-in for the four processor cores that listen to fast_irq.
 assumes fast_irq is a level on clk_sys; each core only latches what it saw.
*/
module fast_irq_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clear,
  input wire logic [3:0] fast_irq,
  output logic [3:0] seen
);
  // sticky per-core record, so a short request is not missed
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      seen <= 4'h0;
    end else if (clear) begin
      seen <= 4'h0;
    end else begin
      seen <= seen | fast_irq;
    end
  end
endmodule // fast_irq_monitor

// >>> interrupt_status_pending_view_test.sv
/*
 self-checking bench for the status and pending view over apb.
 assumes apb answers within a few cycles and all sources are synchronous.
*/
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module interrupt_status_pending_view_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] PG0 = intc_status_pkg::PAGE_GLOBAL;
  localparam logic [2:0] PG1 = intc_status_pkg::PAGE_CORE0;
  localparam logic [8:0] RAW_L = {PG0, intc_status_pkg::OFS_RAW_LOW};
  localparam logic [8:0] RAW_M = {PG0, intc_status_pkg::OFS_RAW_MID};
  localparam logic [8:0] RAW_H = {PG0, intc_status_pkg::OFS_RAW_HIGH};
  localparam logic [8:0] CFG = {PG0, intc_status_pkg::OFS_CFG};
  localparam logic [8:0] SW_S = {PG0, intc_status_pkg::OFS_SW_SET};
  localparam logic [8:0] SW_C = {PG0, intc_status_pkg::OFS_SW_CLR};
  localparam logic [8:0] PND_L = {PG1, intc_status_pkg::OFS_PEND_LOW};
  localparam logic [8:0] PND_H = {PG1, intc_status_pkg::OFS_PEND_HIGH};
  localparam logic [8:0] EN_S = {PG1, intc_status_pkg::OFS_SET_EN0};
  localparam logic [8:0] EN_C = {PG1, intc_status_pkg::OFS_CLR_EN0};
  localparam logic [2:0] PG3 = PG1 + 3'h2;
  localparam logic [8:0] PND_M = {PG1, intc_status_pkg::OFS_PEND_MID};
  localparam logic [8:0] EN_S1 = {PG1, intc_status_pkg::OFS_SET_EN1};
  localparam logic [8:0] EN_S2 = {PG1, intc_status_pkg::OFS_SET_EN2};
  localparam logic [8:0] EN_C1 = {PG1, intc_status_pkg::OFS_CLR_EN1};
  localparam logic [8:0] EN_C2 = {PG1, intc_status_pkg::OFS_CLR_EN2};
  localparam logic [8:0] CORE2_EN = {PG3, intc_status_pkg::OFS_SET_EN0};
  localparam logic [8:0] CORE2_PND = {PG3, intc_status_pkg::OFS_PEND_LOW};
  localparam logic [8:0] NO_PAGE = {PG1 + 3'h4, 6'h00};
  localparam logic [8:0] NO_OFS = {PG0, 6'h18};
  int fail_count = 0;
  int comparisons = 0;
  logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [8:0] paddr = 9'h000;
  logic [31:0] pwdata = 32'h00000000, source_bits_low = 32'h00000000;
  logic [31:0] source_bits_mid = 32'h00000000, prdata;
  logic pready, pslverr, host_irq = 1'b0, axi_error = 1'b0, burst_valid = 1'b0;
  logic [7:0] burst_len = 8'h00;
  logic burst_to_vp_space = 1'b0, first_core_halt = 1'b0, second_core_halt = 1'b0;
  logic [1:0] doorbell_set = 2'h0, doorbell_read = 2'h0;
  logic mailbox_zero_flag = 1'b0, timer_event = 1'b0, timer_ctrl_write = 1'b0;
  logic cluster_reset = 1'b0, mon_clear = 1'b0;
  logic [3:0] fast_irq, seen;
  interrupt_status_pending_view dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .source_bits_low, .source_bits_mid, .host_irq,
    .axi_error, .burst_valid, .burst_len, .burst_to_vp_space, .first_core_halt,
    .second_core_halt, .doorbell_set, .doorbell_read, .mailbox_zero_flag, .timer_event,
    .timer_ctrl_write, .cluster_reset, .fast_irq);
  fast_irq_monitor cores (.clk_sys, .rst, .clear(mon_clear), .fast_irq, .seen);
  // 40 MHz system clock
  always #12.5 clk_sys = ~clk_sys;
  // verdict and end of run, reached from the main flow or a timeout
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // one apb transfer; an idle cycle follows so psel never toggles twice in a step
  task automatic apb(input logic w, input logic [8:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // a hung slave counts as a mismatch
    if (pready !== 1'b1) begin
      fail_count++;
      finish_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h00000000, q, e);
    `CHK(q, exp)
  endtask
  // raw words ignore enables; pending and fast line follow core 0 enables only
  task automatic masking_scenario();
    source_bits_low <= 32'hA5A50001;
    source_bits_mid <= 32'h00008000;
    rd(RAW_L, 32'hA5A50001);
    rd(RAW_M, 32'h00008000);
    rd(PND_L, 32'h00000000);
    wr(EN_S, 32'h00000001);
    rd(PND_L, 32'h00000001);
    rd(PND_H, 32'h01000000);
    `CHK(fast_irq, 4'h1)
    `CHK(seen, 4'h1)
    wr(EN_C, 32'h00000001);
    rd(EN_S, 32'h00000000);
    `CHK(fast_irq, 4'h0)
  endtask
  // top word sources: software, sticky errors, doorbell, timer, halts, host line
  task automatic top_word_scenario();
    wr(SW_S, 32'h00000081);
    wr(RAW_H, 32'hFFFFFFFF);
    rd(RAW_H, 32'h00008100);
    wr(SW_C, 32'h00000001);
    rd(SW_S, 32'h00000080);
    wr(SW_C, 32'h00000080);
    axi_error <= 1'b1;
    burst_valid <= 1'b1;
    burst_to_vp_space <= 1'b1;
    timer_event <= 1'b1;
    doorbell_set <= 2'h2;
    @(posedge clk_sys);
    {axi_error, burst_valid, timer_event, doorbell_set} <= 5'h00;
    rd(RAW_H, 32'h00000089);
    burst_valid <= 1'b1;
    burst_len <= 8'h02;
    timer_ctrl_write <= 1'b1;
    doorbell_read <= 2'h2;
    @(posedge clk_sys);
    {burst_valid, timer_ctrl_write, doorbell_read} <= 4'h0;
    rd(RAW_H, 32'h000000C0);
    cluster_reset <= 1'b1;
    @(posedge clk_sys);
    cluster_reset <= 1'b0;
    second_core_halt <= 1'b1;
    host_irq <= 1'b1;
    rd(RAW_H, 32'h80000020);
    wr(CFG, 32'h00000400);
    rd(RAW_H, 32'h80000030);
  endtask
  // halt, mailbox, doorbell 0, summaries, top mask, core copies, unmapped space
  task automatic core_scenario();
    logic [31:0] q;
    logic e;
    second_core_halt <= 1'b0;
    first_core_halt <= 1'b1;
    rd(RAW_H, 32'h80000010);
    mailbox_zero_flag <= 1'b1;
    doorbell_set <= 2'h1;
    @(posedge clk_sys);
    doorbell_set <= 2'h0;
    rd(RAW_H, 32'h80000016);
    mailbox_zero_flag <= 1'b0;
    doorbell_read <= 2'h1;
    @(posedge clk_sys);
    doorbell_read <= 2'h0;
    rd(RAW_H, 32'h80000010);
    wr(EN_S2, 32'hFFFFFFFF);
    rd(EN_C2, 32'h8000FFFF);
    rd(PND_H, 32'h80000010);
    wr(EN_C2, 32'hFFFFFFFF);
    wr(EN_S1, 32'h00008000);
    rd(PND_M, 32'h00008000);
    rd(PND_H, 32'h02000000);
    wr(EN_C1, 32'h00008000);
    `CHK(fast_irq, 4'h0)
    mon_clear <= 1'b1;
    @(posedge clk_sys);
    mon_clear <= 1'b0;
    @(posedge clk_sys);
    `CHK(seen, 4'h0)
    wr(CORE2_EN, 32'h00000001);
    rd(CORE2_PND, 32'h00000001);
    rd(PND_L, 32'h00000000);
    `CHK(fast_irq, 4'h4)
    `CHK(seen, 4'h4)
    apb(1'b0, RAW_L, 32'h00000000, q, e);
    `CHK(e, 1'b0)
    apb(1'b0, NO_PAGE, 32'h00000000, q, e);
    `CHK(e, 1'b1)
    `CHK(q, 32'h00000000)
    apb(1'b1, NO_OFS, 32'hFFFFFFFF, q, e);
    `CHK(e, 1'b1)
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(RAW_H, 32'h00000000);
    masking_scenario();
    top_word_scenario();
    core_scenario();
    finish_test();
  end
endmodule // interrupt_status_pending_view_test
